// ===== hbi_top.v
// What this block does
// - never both gates on with interlock enabled
// - gap is max of controller and internal
// - inverted single command pair works correctly
// - overlapping commands raise no error
// - straps pick 1 to 4 us, plus 0.3
// - disable strap with open straps: no interlock
// - watch sense only while on; trip off
// - raised reference after turn-on, restored at off
// - ignore sense during blanking after turn-on
// - trip turns off, sets memory, hold high
// - high command means on, low off
// - hold 3 s, no supply fault, idle 9 us
`timescale 1ns/10ps
`include "hbi_defs.vh"

module hbi_top #(
	parameter [`HBI_FAIL_W-1:0] FAIL_HOLD_CYC =
		`HBI_FAIL_HOLD_CYC
) (
	// clock and reset
	input  wire MCLK,
	input  wire RST,
	// switch commands from the controller
	input  wire HIGH_SIDE_COMMAND,
	input  wire LOW_SIDE_COMMAND,
	// configuration straps, high when open
	input  wire DEADTIME_STRAP_ONE,
	input  wire DEADTIME_STRAP_TWO,
	input  wire DEADTIME_STRAP_THREE,
	input  wire INTERLOCK_DISABLE_STRAP,
	// desaturation comparators, high when sense above reference
	input  wire HIGH_SIDE_SENSE_INPUT,
	input  wire LOW_SIDE_SENSE_INPUT,
	// supply monitor, high while a supply fault stands
	input  wire SUPPLY_FAULT,
	// gate drive
	output wire HIGH_SIDE_GATE,
	output wire LOW_SIDE_GATE,
	// reference shaping, high while the raised value applies
	output wire HIGH_SIDE_REF_RAISE,
	output wire LOW_SIDE_REF_RAISE,
	// status
	output wire FAULT_HOLD_OUTPUT,
	output wire HALT_STATUS_OUTPUT
);

	////////////////////////////////////////////////////////////////////
	// states and derived cycle counts

	localparam [1:0] ST_BOOT = 2'h0;
	localparam [1:0] ST_RUN  = 2'h1;
	localparam [1:0] ST_HALT = 2'h2;

	localparam integer STEP_RAW =
		(`HBI_DT_STEP_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS;
	localparam integer EXTRA_RAW =
		(`HBI_DT_EXTRA_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS;
	localparam integer IDLE_RAW =
		(`HBI_IDLE_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS;
	// rounded up to whole cycles, then cut to the counter widths
	localparam [`HBI_CNT_W-1:0]  STEP_CYC  = STEP_RAW[`HBI_CNT_W-1:0];
	localparam [`HBI_CNT_W-1:0]  EXTRA_CYC = EXTRA_RAW[`HBI_CNT_W-1:0];
	localparam [`HBI_IDLE_W-1:0] IDLE_CYC  = IDLE_RAW[`HBI_IDLE_W-1:0];

	////////////////////////////////////////////////////////////////////
	// declarations

	reg  [8:0]             meta_ff;
	reg  [8:0]             sync_ff;
	wire                   cmd_h;
	wire                   cmd_l;
	wire                   strap_one;
	wire                   strap_two;
	wire                   strap_three;
	wire                   strap_dis;
	wire                   sense_h;
	wire                   sense_l;
	wire                   supply_bad;

	reg  [1:0]             state_ff;
	reg  [1:0]             nxt_state;
	reg  [1:0]             strap_wait_ff;
	reg  [1:0]             nxt_strap_wait;
	reg  [`HBI_CNT_W-1:0]  dt_cyc_ff;
	reg  [`HBI_CNT_W-1:0]  nxt_dt_cyc;
	reg  [`HBI_CNT_W-1:0]  dt_base;
	reg                    il_en_ff;
	reg                    nxt_il_en;

	reg                    gate_h_ff;
	reg                    gate_l_ff;
	reg                    nxt_gate_h;
	reg                    nxt_gate_l;
	reg                    hold_ff;
	reg                    nxt_hold;
	reg                    halt_ff;
	reg                    nxt_halt;

	reg  [`HBI_FAIL_W-1:0] fail_cnt_ff;
	reg  [`HBI_FAIL_W-1:0] nxt_fail_cnt;
	reg  [`HBI_IDLE_W-1:0] idle_cnt_ff;
	reg  [`HBI_IDLE_W-1:0] nxt_idle_cnt;

	wire                   off_done_h;
	wire                   off_done_l;
	wire                   trip_h;
	wire                   trip_l;
	wire                   fault_now;
	wire                   run_ok;
	wire                   fail_done;
	wire                   idle_ok;

	////////////////////////////////////////////////////////////////////
	// two-stage synchronisers for every pin input except clock and reset

	always @(posedge MCLK)
	begin
		if (RST)
		begin
			meta_ff <= `HBI_SYNC_RST;
			sync_ff <= `HBI_SYNC_RST;
		end
		else
		begin
			meta_ff <= {SUPPLY_FAULT, LOW_SIDE_SENSE_INPUT,
				HIGH_SIDE_SENSE_INPUT, INTERLOCK_DISABLE_STRAP,
				DEADTIME_STRAP_THREE, DEADTIME_STRAP_TWO,
				DEADTIME_STRAP_ONE, LOW_SIDE_COMMAND,
				HIGH_SIDE_COMMAND};
			sync_ff <= meta_ff;
		end
	end

	// high command asks for on, low for off
	assign cmd_h       = sync_ff[0];
	assign cmd_l       = sync_ff[1];
	assign strap_one   = sync_ff[2];
	assign strap_two   = sync_ff[3];
	assign strap_three = sync_ff[4];
	assign strap_dis   = sync_ff[5];
	assign sense_h     = sync_ff[6];
	assign sense_l     = sync_ff[7];
	assign supply_bad  = sync_ff[8];

	////////////////////////////////////////////////////////////////////
	// dead time and interlock selection from the straps

	always @*
	begin
		case ({strap_one, strap_two})
		2'b00:
			dt_base = STEP_CYC;
		2'b01:
			dt_base = STEP_CYC + STEP_CYC;
		2'b10:
			dt_base = STEP_CYC + STEP_CYC + STEP_CYC;
		2'b11:
			dt_base = {STEP_CYC[`HBI_CNT_W-3:0], 2'b00};
		default:
			dt_base = {STEP_CYC[`HBI_CNT_W-3:0], 2'b00};
		endcase
		// a grounded third strap lengthens the gap
		nxt_dt_cyc = dt_base +
			(strap_three ? {`HBI_CNT_W{1'b0}} : EXTRA_CYC);
		// grounded disable with all time straps open
		nxt_il_en = ~(~strap_dis & strap_one & strap_two &
			strap_three);
	end

	////////////////////////////////////////////////////////////////////
	// per-side dead time, blanking and desaturation

	hbi_channel u_high (
		.clk          (MCLK),
		.rst          (RST),
		.gate_on      (gate_h_ff),
		.sense_hi     (sense_h),
		.dt_cyc       (dt_cyc_ff),
		.off_done     (off_done_h),
		.trip         (trip_h),
		.ref_raise_ff (HIGH_SIDE_REF_RAISE)
	);

	hbi_channel u_low (
		.clk          (MCLK),
		.rst          (RST),
		.gate_on      (gate_l_ff),
		.sense_hi     (sense_l),
		.dt_cyc       (dt_cyc_ff),
		.off_done     (off_done_l),
		.trip         (trip_l),
		.ref_raise_ff (LOW_SIDE_REF_RAISE)
	);

	////////////////////////////////////////////////////////////////////
	// gate drive with interlock

	// overlapping commands are no fault: only the drive is withheld
	assign fault_now = trip_h | trip_l | supply_bad;
	assign run_ok    = (state_ff == ST_RUN) & ~fault_now;

	always @*
	begin
		// each side waits for the other gate to be off a full dead time
		nxt_gate_h = run_ok & cmd_h &
			(~il_en_ff | (~gate_l_ff & off_done_l));
		// high wins a tie, so a plain inverted pair never collides
		nxt_gate_l = run_ok & cmd_l &
			(~il_en_ff | (~gate_h_ff & off_done_h &
			~nxt_gate_h));
	end

	////////////////////////////////////////////////////////////////////
	// failure sequencing

	assign fail_done = (fail_cnt_ff == FAIL_HOLD_CYC);
	// idle must be strictly longer than the minimum
	assign idle_ok   = (idle_cnt_ff > IDLE_CYC);

	always @*
	begin
		nxt_state      = state_ff;
		nxt_strap_wait = strap_wait_ff;
		nxt_hold       = hold_ff;
		nxt_halt       = halt_ff;
		nxt_fail_cnt   = fail_cnt_ff;
		// idle counts only while both commands sit low
		if (cmd_h | cmd_l)
			nxt_idle_cnt = {`HBI_IDLE_W{1'b0}};
		else if (!idle_ok)
			nxt_idle_cnt = idle_cnt_ff + 1'b1;
		else
			nxt_idle_cnt = idle_cnt_ff;
		case (state_ff)
		ST_BOOT:
		begin
			// straps settle through the synchronisers first
			if (strap_wait_ff == `HBI_STRAP_WAIT)
			begin
				nxt_state = ST_RUN;
				nxt_halt  = 1'b0;
			end
			else
				nxt_strap_wait = strap_wait_ff + 1'b1;
		end
		ST_RUN:
		begin
			if (fault_now)
			begin
				nxt_state    = ST_HALT;
				nxt_hold     = 1'b1;
				nxt_halt     = 1'b1;
				nxt_fail_cnt = {`HBI_FAIL_W{1'b0}};
			end
		end
		ST_HALT:
		begin
			if (!fail_done)
				nxt_fail_cnt = fail_cnt_ff + 1'b1;
			// a new trip during hold cannot occur: gates are off
			if (fail_done & ~supply_bad & idle_ok)
			begin
				nxt_state = ST_RUN;
				nxt_hold  = 1'b0;
				nxt_halt  = 1'b0;
			end
		end
		default:
		begin
			nxt_state = ST_HALT;
			nxt_hold  = 1'b1;
			nxt_halt  = 1'b1;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// state, configuration and outputs

	always @(posedge MCLK)
	begin
		if (RST)
		begin
			state_ff      <= ST_BOOT;
			strap_wait_ff <= 2'h0;
			dt_cyc_ff     <= {`HBI_CNT_W{1'b0}};
			il_en_ff      <= `HBI_CFG_IL_RST;
			gate_h_ff     <= `HBI_GATE_RST;
			gate_l_ff     <= `HBI_GATE_RST;
			hold_ff       <= `HBI_HOLD_RST;
			halt_ff       <= `HBI_HALT_RST;
			fail_cnt_ff   <= {`HBI_FAIL_W{1'b0}};
			idle_cnt_ff   <= {`HBI_IDLE_W{1'b0}};
		end
		else
		begin
			state_ff      <= nxt_state;
			strap_wait_ff <= nxt_strap_wait;
			// straps are caught in every boot cycle after reset release, then held
			if (state_ff == ST_BOOT)
			begin
				dt_cyc_ff <= nxt_dt_cyc;
				il_en_ff  <= nxt_il_en;
			end
			gate_h_ff     <= nxt_gate_h;
			gate_l_ff     <= nxt_gate_l;
			hold_ff       <= nxt_hold;
			halt_ff       <= nxt_halt;
			fail_cnt_ff   <= nxt_fail_cnt;
			idle_cnt_ff   <= nxt_idle_cnt;
		end
	end

	assign HIGH_SIDE_GATE     = gate_h_ff;
	assign LOW_SIDE_GATE      = gate_l_ff;
	assign FAULT_HOLD_OUTPUT  = hold_ff;
	assign HALT_STATUS_OUTPUT = halt_ff;

endmodule

// ===== hbi_defs.vh
`ifndef HBI_DEFS_VH
`define HBI_DEFS_VH

////////////////////////////////////////////////////////////////////////
// clock and timing figures, in their own units
`define HBI_CLK_NS        8
`define HBI_DT_STEP_NS    1000
`define HBI_DT_EXTRA_NS   300
`define HBI_BLANK_NS      2000
`define HBI_IDLE_NS       9000
`define HBI_FAIL_HOLD_MS  3000
// the same hold in clock cycles, sized for the failure counter
`define HBI_FAIL_HOLD_CYC 29'h165A0BC0

////////////////////////////////////////////////////////////////////////
// counter widths
`define HBI_CNT_W         10
`define HBI_IDLE_W        11
`define HBI_FAIL_W        29

////////////////////////////////////////////////////////////////////////
// strap settling after reset release, in cycles
`define HBI_STRAP_WAIT    2'h3

////////////////////////////////////////////////////////////////////////
// reset values
`define HBI_GATE_RST      1'h0
`define HBI_HOLD_RST      1'h0
`define HBI_HALT_RST      1'h1
`define HBI_REF_RST       1'h1
`define HBI_CFG_IL_RST    1'h1
`define HBI_SYNC_RST      9'h000

`endif

// ===== hbi_channel.v
`timescale 1ns/10ps
`include "hbi_defs.vh"

module hbi_channel (
	// clock and reset
	input  wire                  clk,
	input  wire                  rst,
	// this side's gate and settings
	input  wire                  gate_on,
	input  wire                  sense_hi,
	input  wire [`HBI_CNT_W-1:0] dt_cyc,
	// status to the interlock and fault logic, plus the raised-reference output
	output wire                  off_done,
	output wire                  trip,
	output reg                   ref_raise_ff
);

	// whole cycles, rounded up, then cut to the counter width
	localparam integer BLANK_RAW =
		(`HBI_BLANK_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS;
	localparam [`HBI_CNT_W-1:0] BLANK_CYC = BLANK_RAW[`HBI_CNT_W-1:0];

	reg  [`HBI_CNT_W-1:0] off_cnt_ff;
	reg  [`HBI_CNT_W-1:0] blank_cnt_ff;
	reg  [`HBI_CNT_W-1:0] nxt_off_cnt;
	reg  [`HBI_CNT_W-1:0] nxt_blank_cnt;
	wire                  blank_done;

	////////////////////////////////////////////////////////////////////
	// off time since this gate fell, saturating at the dead time
	always @*
	begin
		if (gate_on)
			nxt_off_cnt = {`HBI_CNT_W{1'b0}};
		else if (off_cnt_ff < dt_cyc)
			nxt_off_cnt = off_cnt_ff + 1'b1;
		else
			nxt_off_cnt = off_cnt_ff;
	end

	// a slow controller gap saturates the count first, so no sum
	assign off_done = (off_cnt_ff >= dt_cyc);

	////////////////////////////////////////////////////////////////////
	// blanking from each turn-on, cleared whenever the gate is off
	always @*
	begin
		if (!gate_on)
			nxt_blank_cnt = {`HBI_CNT_W{1'b0}};
		else if (blank_cnt_ff != BLANK_CYC)
			nxt_blank_cnt = blank_cnt_ff + 1'b1;
		else
			nxt_blank_cnt = blank_cnt_ff;
	end

	assign blank_done = (blank_cnt_ff == BLANK_CYC);

	// comparison only counts while on and past blanking
	assign trip = gate_on & blank_done & sense_hi;

	////////////////////////////////////////////////////////////////////
	// counters and the raised-reference control
	always @(posedge clk)
	begin
		if (rst)
		begin
			off_cnt_ff   <= {`HBI_CNT_W{1'b0}};
			blank_cnt_ff <= {`HBI_CNT_W{1'b0}};
			ref_raise_ff <= `HBI_REF_RST;
		end
		else
		begin
			off_cnt_ff   <= nxt_off_cnt;
			blank_cnt_ff <= nxt_blank_cnt;
			// raised until blanking ends, restored at turn-off
			ref_raise_ff <= ~(gate_on & blank_done);
		end
	end

endmodule

// ===== hbi_top_props.sv
`timescale 1ns/10ps
module hbi_top_props #(
	parameter int FAIL_HOLD_CYC = 200
) (
	// clock, reset, commands, straps
	input wire MCLK,
	input wire RST,
	input wire HIGH_SIDE_COMMAND,
	input wire LOW_SIDE_COMMAND,
	input wire DEADTIME_STRAP_ONE,
	input wire DEADTIME_STRAP_TWO,
	input wire DEADTIME_STRAP_THREE,
	input wire INTERLOCK_DISABLE_STRAP,
	// sense and supply
	input wire HIGH_SIDE_SENSE_INPUT,
	input wire LOW_SIDE_SENSE_INPUT,
	input wire SUPPLY_FAULT,
	// watched outputs
	input wire HIGH_SIDE_GATE,
	input wire LOW_SIDE_GATE,
	input wire HIGH_SIDE_REF_RAISE,
	input wire FAULT_HOLD_OUTPUT,
	input wire HALT_STATUS_OUTPUT
);
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (RST);
	int         dt;
	wire        il_on;
	int         lo_off_ff = 0;
	int         idle_ff = 0;
	int         halt_ff = 0;
	logic [3:0] cause_ff = 4'h0;
	////////////////////////////////////////
	// straps only move in reset, so the live pins stand in for the latch
	assign dt = 125 * ({DEADTIME_STRAP_ONE, DEADTIME_STRAP_TWO} + 1)
		+ (DEADTIME_STRAP_THREE ? 0 : 38);
	assign il_on = INTERLOCK_DISABLE_STRAP || !(DEADTIME_STRAP_ONE
		&& DEADTIME_STRAP_TWO && DEADTIME_STRAP_THREE);
	// cause history covers the sync flops plus the trip register
	always @(posedge MCLK)
	begin
		lo_off_ff <= (RST || LOW_SIDE_GATE) ? 0 : lo_off_ff + 1;
		idle_ff <= (HIGH_SIDE_COMMAND || LOW_SIDE_COMMAND) ? 0
			: idle_ff + 1;
		halt_ff <= HALT_STATUS_OUTPUT ? halt_ff + 1 : 0;
		cause_ff <= {cause_ff[2:0], SUPPLY_FAULT
			|| HIGH_SIDE_SENSE_INPUT || LOW_SIDE_SENSE_INPUT};
	end
	////////////////////////////////////////
	// desaturation seen past blanking, then the latched fault
	sequence s_hi_desat;
		(HIGH_SIDE_GATE && !HIGH_SIDE_REF_RAISE && HIGH_SIDE_COMMAND
			&& HIGH_SIDE_SENSE_INPUT) [*2];
	endsequence
	sequence s_tripped;
		FAULT_HOLD_OUTPUT && HALT_STATUS_OUTPUT && !HIGH_SIDE_GATE;
	endsequence
	a_no_shoot_thru: assert property (il_on
		|-> !(HIGH_SIDE_GATE && LOW_SIDE_GATE)) else $error("gates overlap");
	a_dead_time: assert property (il_on && $rose(HIGH_SIDE_GATE)
		|-> lo_off_ff >= dt) else $error("dead time too short");
	a_gap_not_added: assert property ($rose(HIGH_SIDE_COMMAND)
		&& !LOW_SIDE_COMMAND && lo_off_ff > dt && !HALT_STATUS_OUTPUT
		&& !SUPPLY_FAULT |-> ##[1:4] HIGH_SIDE_GATE) else $error("gate late");
	a_cmd_off: assert property ($fell(HIGH_SIDE_COMMAND)
		|-> ##[1:3] !HIGH_SIDE_GATE) else $error("gate stays on");
	a_pass_thru: assert property (!il_on && $rose(LOW_SIDE_COMMAND)
		&& !HALT_STATUS_OUTPUT && !SUPPLY_FAULT |-> ##[1:4] LOW_SIDE_GATE)
		else $error("no pass-through");
	a_desat_trip: assert property (s_hi_desat |=> ##[0:2] s_tripped)
		else $error("desaturation not tripped");
	a_blank_window: assert property ($rose(HIGH_SIDE_GATE)
		|-> (HIGH_SIDE_REF_RAISE && !FAULT_HOLD_OUTPUT) [*8])
		else $error("blanking broken");
	a_ref_restore: assert property ($fell(HIGH_SIDE_GATE)
		|-> ##[0:2] HIGH_SIDE_REF_RAISE) else $error("reference not raised");
	a_halt_gates: assert property (HALT_STATUS_OUTPUT
		|-> !HIGH_SIDE_GATE && !LOW_SIDE_GATE) else $error("gate in halt");
	a_err_cause: assert property ($rose(FAULT_HOLD_OUTPUT)
		|-> |cause_ff) else $error("error without cause");
	a_release_wait: assert property ($fell(FAULT_HOLD_OUTPUT)
		|-> !HALT_STATUS_OUTPUT && idle_ff > 1125
		&& halt_ff >= FAIL_HOLD_CYC - 1) else $error("early release");
endmodule
bind hbi_top hbi_top_props #(.FAIL_HOLD_CYC(FAIL_HOLD_CYC)) hbi_top_props_i (.*);

// ===== hbi_pwm_ctrl.sv
`timescale 1ns/10ps
module hbi_pwm_ctrl (
	// carrier settings
	input wire        clk,
	input wire        run,
	input wire        inv,
	input wire [10:0] half,
	input wire [10:0] gap,
	// switch commands
	output logic      hi_cmd,
	output logic      lo_cmd
);
	int cnt = 0;
	////////////////////////////////////////
	// moves on the edge by nba, so the sync flops see a clean level
	always @(posedge clk)
	begin
		cnt <= (run && cnt < 2 * half - 1) ? cnt + 1 : 0;
		hi_cmd <= run && cnt < half;
		lo_cmd <= run && (inv ? cnt >= half
			: cnt >= half + gap && cnt < 2 * half - gap);
	end
endmodule

// ===== hbi_top_tb.sv
`timescale 1ns/10ps
module hbi_top_tb;
	localparam int HOLD_CYC = 600;
	logic        MCLK = 1'h0;
	logic        RST = 1'h1;
	logic        SUPPLY_FAULT = 1'h0;
	logic [1:0]  cmd = 2'h0; // bit 0 high side
	logic [1:0]  sns = 2'h0;
	logic [3:0]  strap = 4'hF; // one, two, three, disable
	logic        run = 1'h0;
	logic        inv = 1'h0;
	logic [10:0] half = 11'h0C8;
	logic [10:0] gap = 11'h000;
	wire         m_hi;
	wire         m_lo;
	wire [1:0]   gate;
	wire [1:0]   raise;
	wire         hold;
	wire         halt;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          k, e, got, i, s;
	////////////////////////////////////////
	hbi_top #(.FAIL_HOLD_CYC(HOLD_CYC)) hbi_top_i (
		.MCLK(MCLK),
		.RST(RST),
		.HIGH_SIDE_COMMAND(run ? m_hi : cmd[0]),
		.LOW_SIDE_COMMAND(run ? m_lo : cmd[1]),
		.DEADTIME_STRAP_ONE(strap[3]),
		.DEADTIME_STRAP_TWO(strap[2]),
		.DEADTIME_STRAP_THREE(strap[1]),
		.INTERLOCK_DISABLE_STRAP(strap[0]),
		.HIGH_SIDE_SENSE_INPUT(sns[0]),
		.LOW_SIDE_SENSE_INPUT(sns[1]),
		.SUPPLY_FAULT(SUPPLY_FAULT),
		.HIGH_SIDE_GATE(gate[0]),
		.LOW_SIDE_GATE(gate[1]),
		.HIGH_SIDE_REF_RAISE(raise[0]),
		.LOW_SIDE_REF_RAISE(raise[1]),
		.FAULT_HOLD_OUTPUT(hold),
		.HALT_STATUS_OUTPUT(halt)
	);
	hbi_pwm_ctrl hbi_pwm_ctrl_i (.clk(MCLK), .run(run), .inv(inv),
		.half(half), .gap(gap), .hi_cmd(m_hi), .lo_cmd(m_lo));
	initial forever #4 MCLK = ~MCLK;
	////////////////////////////////////////
	// expected interlock gap per strap code, zero for pass-through
	function automatic int exp_dt(input int code);
		return code == 8 ? 0 : 125 * (code / 2 + 1) + (code % 2 ? 0 : 38);
	endfunction
	task automatic chk(input string what, input logic seen, input logic exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic chk_rng(input string what, input int seen, input int lo,
		input int hi);
		samples_checked++;
		if (seen < lo || seen > hi)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
				hi, seen);
		end
	endtask
	task results;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// straps only change under reset, commands low
	task automatic boot(input logic [3:0] code);
		strap = code;
		RST = 1'h1;
		repeat (6) @(negedge MCLK);
		RST = 1'h0;
		for (i = 0; i < 20 && halt !== 1'h0; i++) @(negedge MCLK);
		chk("halt after boot", halt, 1'h0);
	endtask
	// cycles from high gate off to low gate on, low command g cycles late
	task automatic gap_run(input int g, output int gap_seen);
		int j, hf;
		hf = -1;
		cmd = 2'h1;
		repeat (700) @(negedge MCLK);
		cmd = g ? 2'h0 : 2'h2;
		for (j = 1; j < 2000 && gate[1] !== 1'h1; j++)
		begin
			@(negedge MCLK);
			if (j == g)
				cmd = 2'h2;
			if (gate[0] === 1'h0 && hf < 0)
				hf = j;
		end
		gap_seen = j - 1 - hf;
	endtask
	// a hang counts as a mismatch; the full run is near 40k cycles
	initial
	begin
		#480000;
		n_fail++;
		results;
	end
	////////////////////////////////////////
	initial
	begin
		void'($urandom(66626));
		// each dead-time strap code plus pass-through: inverted pair, late controller, overlap
		for (k = 0; k < 9; k++)
		begin
			e = exp_dt(k);
			boot(k == 8 ? 4'hE : {k[2:0], 1'h1});
			gap_run(0, got);
			chk_rng("inverse gap", got, e, e + 2);
			cmd = 2'h3;
			repeat (20) @(negedge MCLK);
			chk("overlap high gate", gate[0], k == 8);
			chk("overlap hold", hold, 1'h0);
			cmd = 2'h0;
			repeat (5) @(negedge MCLK);
			gap_run(e + 60, got);
			chk_rng("controller gap", got, e + 60, e + 62);
			cmd = 2'h0;
			repeat (5) @(negedge MCLK);
		end
		// random carrier with random straps; the checker guards overlap
		for (k = 0; k < 4; k++)
		begin
			boot({3'($urandom_range(7, 0)), 1'($urandom_range(1, 0))});
			half = 11'($urandom_range(1500, 200));
			gap = 11'($urandom_range(100, 0));
			inv = 1'($urandom_range(1, 0));
			run = 1'h1;
			repeat (4000) @(negedge MCLK);
			chk("hold after carrier", hold, 1'h0);
			run = 1'h0;
			repeat (4) @(negedge MCLK);
		end
		// desaturation on each side: off, blanked, then tripped
		boot(4'h1);
		for (s = 0; s < 2; s++)
		begin
			sns[s] = 1'h1;
			repeat (200) @(negedge MCLK);
			chk("sense while off", hold, 1'h0);
			cmd[s] = 1'h1;
			for (i = 0; i < 600 && gate[s] !== 1'h1; i++) @(negedge MCLK);
			repeat (100) @(negedge MCLK);
			chk("gate in blanking", gate[s], 1'h1);
			chk("hold in blanking", hold, 1'h0);
			for (i = 0; i < 300 && hold !== 1'h1; i++) @(negedge MCLK);
			chk("trip gate", gate[s], 1'h0);
			chk("trip halt", halt, 1'h1);
			// the reference follows the gate one cycle later
			@(negedge MCLK);
			chk("ref raised", raise[s], 1'h1);
			cmd = 2'h0;
			sns = 2'h0;
			for (i = 0; i < 3000 && halt !== 1'h0; i++) @(negedge MCLK);
			chk_rng("idle release", i, 1125, 1135);
		end
		// supply fault: release waits for the hold time
		SUPPLY_FAULT = 1'h1;
		repeat (5) @(negedge MCLK);
		chk("supply hold", hold, 1'h1);
		SUPPLY_FAULT = 1'h0;
		for (i = 0; i < 3000 && halt !== 1'h0; i++) @(negedge MCLK);
		chk_rng("hold release", i, HOLD_CYC - 10, HOLD_CYC + 6);
		// high side: sense rises only once blanking is over
		cmd[0] = 1'h1;
		repeat (300) @(negedge MCLK);
		chk("ref after blanking", raise[0], 1'h0);
		sns[0] = 1'h1;
		repeat (4) @(negedge MCLK);
		chk("late trip hold", hold, 1'h1);
		chk("late trip gate", gate[0], 1'h0);
		cmd = 2'h0;
		sns = 2'h0;
		results;
	end
endmodule
